// ===== rtl/bmr_registers.sv
// Brown-out monitor register bank with Avalon-MM slave
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
module bmr_registers
   import bmr_pkg::*;
#(
   parameter int unsigned SAMPLE_FAST_CYCLES = BMR_SAMPLE_FAST_CYCLES,
   parameter int unsigned SAMPLE_SLOW_CYCLES = BMR_SAMPLE_SLOW_CYCLES,
   parameter int unsigned UNLOCK_WINDOW_CYCLES = BMR_UNLOCK_WINDOW_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire bmr_fuse_t fuse_config,
   input wire logic sleep_deep,
   input wire logic config_change_unlock,
   input wire logic warning_below_raw,
   input wire logic detector_ready_raw,
   output bmr_analog_t analog_ctrl,
   output logic warning_irq,
   output logic exec_hold
);
   localparam int unsigned TW = $clog2(SAMPLE_SLOW_CYCLES + SAMPLE_FAST_CYCLES + 1);
   localparam logic [TW-1:0] FAST_RELOAD = TW'(SAMPLE_FAST_CYCLES - 1);
   localparam logic [TW-1:0] SLOW_RELOAD = TW'(SAMPLE_SLOW_CYCLES - 1);

   typedef struct packed {
      bmr_bus_st_t bus_st;
      logic waitrequest;
      logic [31:0] readdata;
      logic sample_rate_select;
      bmr_mode_t awake_mode;
      bmr_mode_t lowpower_mode;
      logic [2:0] threshold_level;
      logic [1:0] warning_margin_select;
      bmr_dir_t warning_direction_select;
      logic warning_irq_enable;
      logic warning_irq_flag;
      logic irq;
      logic [TW-1:0] tick_cnt;
      logic tick;
      logic det_enable;
      logic det_sampled;
      logic sleep_prev;
      logic ready_sync1;
      logic ready_sync2;
      logic hold;
   } bmr_state_t;

   bmr_state_t s_q;
   bmr_state_t s_d;

   logic prot_open;
   logic prot_consume;
   logic warn_below;
   logic warn_fell;
   logic warn_rose;
   logic commit;
   logic [3:0] idx;
   logic [7:0] wbyte;
   bmr_mode_t mode_now;
   logic set_flag;
   logic clr_flag;
   logic woke;

   // Register index from a byte address; the low two bits are dropped and do not select a lane
   function automatic logic [3:0] reg_index(input logic [5:0] addr);
      return addr[5:2];
   endfunction

   function automatic logic [7:0] reg_read(input bmr_state_t s, input logic [3:0] i, input logic below);
      logic [7:0] v;
      v = 8'h00;
      case (i)
         BMR_IDX_DETECTOR_CONTROL: begin
            v[BMR_RATE_BIT] = s.sample_rate_select;
            v[BMR_AWAKE_LSB +: 2] = s.awake_mode;
            v[BMR_LOWPOWER_LSB +: 2] = s.lowpower_mode;
         end
         BMR_IDX_THRESHOLD_LEVEL: begin
            v[BMR_LEVEL_LSB +: 3] = s.threshold_level;
         end
         BMR_IDX_WARNING_MARGIN_CONTROL: begin
            v[BMR_MARGIN_LSB +: 2] = s.warning_margin_select;
         end
         BMR_IDX_INTERRUPT_CONTROL: begin
            v[BMR_DIR_LSB +: 2] = s.warning_direction_select;
            v[BMR_IRQ_EN_BIT] = s.warning_irq_enable;
         end
         BMR_IDX_INTERRUPT_FLAGS: begin
            v[BMR_FLAG_BIT] = s.warning_irq_flag;
         end
         BMR_IDX_WARNING_STATUS: begin
            v[BMR_STATUS_BIT] = below;
         end
         default: begin
            v = 8'h00;
         end
      endcase
      return v;
   endfunction

   // Does a reported crossing match the chosen direction
   function automatic logic dir_match(input bmr_dir_t d, input logic fell, input logic rose);
      logic m;
      m = 1'b0;
      case (d)
         BMR_DIR_BELOW: m = fell;
         BMR_DIR_ABOVE: m = rose;
         BMR_DIR_CROSS: m = fell | rose;
         default: m = 1'b0;
      endcase
      return m;
   endfunction

   bmr_change_protect #(
      .WINDOW_CYCLES(UNLOCK_WINDOW_CYCLES)
   ) u_protect (
      .clk(clk),
      .reset_n(reset_n),
      .unlock(config_change_unlock),
      .consume(prot_consume),
      .open_q(prot_open)
   );

   bmr_warning_detect u_warning (
      .clk(clk),
      .reset_n(reset_n),
      .below_raw(warning_below_raw),
      .active(s_q.det_enable),
      .sampled(s_q.det_sampled),
      .tick(s_q.tick),
      .below_q(warn_below),
      .fell_q(warn_fell),
      .rose_q(warn_rose)
   );

   always_comb begin
      s_d = s_q;
      idx = reg_index(avs_address);
      wbyte = avs_writedata[7:0];
      commit = 1'b0;

      // One wait state: request seen in IDLE, answered in ACK, write lands at the ACK edge
      case (s_q.bus_st)
         BMR_BUS_IDLE: begin
            s_d.waitrequest = 1'b1;
            if (avs_read || avs_write) begin
               s_d.bus_st = BMR_BUS_ACK;
               s_d.waitrequest = 1'b0;
               s_d.readdata = avs_read ? {24'h00_0000, reg_read(s_q, idx, warn_below)} : 32'h0000_0000;
            end
         end
         BMR_BUS_ACK: begin
            s_d.bus_st = BMR_BUS_IDLE;
            s_d.waitrequest = 1'b1;
            commit = avs_write && avs_byteenable[0];
         end
         default: begin
            s_d.bus_st = BMR_BUS_IDLE;
            s_d.waitrequest = 1'b1;
         end
      endcase

      // Protected field: an unlocked write spends the window, a locked one is dropped
      prot_consume = commit && (idx == BMR_IDX_DETECTOR_CONTROL);
      if (prot_consume && prot_open) begin
         s_d.lowpower_mode = bmr_mode_t'(wbyte[BMR_LOWPOWER_LSB +: 2]);
      end
      if (commit && idx == BMR_IDX_WARNING_MARGIN_CONTROL) begin
         s_d.warning_margin_select = wbyte[BMR_MARGIN_LSB +: 2];
      end
      if (commit && idx == BMR_IDX_INTERRUPT_CONTROL) begin
         s_d.warning_direction_select = bmr_dir_t'(wbyte[BMR_DIR_LSB +: 2]);
         s_d.warning_irq_enable = wbyte[BMR_IRQ_EN_BIT];
      end

      // Detector mode follows sleep state; reserved low-power code leaves it off
      if (sleep_deep) begin
         mode_now = (s_q.lowpower_mode == BMR_MODE_WAKE_HOLD) ? BMR_MODE_OFF : s_q.lowpower_mode;
      end else begin
         mode_now = s_q.awake_mode;
      end
      s_d.det_enable = (mode_now != BMR_MODE_OFF);
      s_d.det_sampled = (mode_now == BMR_MODE_SAMPLED);

      // Sample tick; counter restarts whenever sampling is not in use
      s_d.tick = 1'b0;
      if (!s_q.det_sampled) begin
         s_d.tick_cnt = s_q.sample_rate_select ? SLOW_RELOAD : FAST_RELOAD;
      end else if (s_q.tick_cnt == '0) begin
         s_d.tick = 1'b1;
         s_d.tick_cnt = s_q.sample_rate_select ? SLOW_RELOAD : FAST_RELOAD;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt - TW'(1);
      end

      // Set beats a simultaneous clear so no crossing is lost
      set_flag = s_q.det_enable && dir_match(s_q.warning_direction_select, warn_fell, warn_rose);
      clr_flag = commit && (idx == BMR_IDX_INTERRUPT_FLAGS) && wbyte[BMR_FLAG_BIT];
      s_d.warning_irq_flag = (s_q.warning_irq_flag && !clr_flag) || set_flag;
      s_d.irq = s_d.warning_irq_enable && s_d.warning_irq_flag;

      // Execution hold after wake in the hold variant, released once detector runs
      s_d.ready_sync1 = detector_ready_raw;
      s_d.ready_sync2 = s_q.ready_sync1;
      s_d.sleep_prev = sleep_deep;
      woke = s_q.sleep_prev && !sleep_deep && (s_q.awake_mode == BMR_MODE_WAKE_HOLD);
      s_d.hold = woke || (s_q.hold && !s_q.ready_sync2);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.bus_st <= BMR_BUS_IDLE;
         s_q.waitrequest <= 1'b1;
         // Fuse values are taken while reset is held
         s_q.sample_rate_select <= fuse_config.sample_rate_select;
         s_q.awake_mode <= fuse_config.awake_mode;
         s_q.lowpower_mode <= fuse_config.lowpower_mode;
         s_q.threshold_level <= fuse_config.threshold_level;
         s_q.warning_margin_select <= BMR_MARGIN_RESET;
         s_q.warning_direction_select <= bmr_dir_t'(BMR_DIR_RESET);
         s_q.warning_irq_enable <= BMR_IRQ_EN_RESET;
         s_q.warning_irq_flag <= BMR_FLAG_RESET;
         s_q.tick_cnt <= FAST_RELOAD;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_readdata = s_q.readdata;
   assign avs_waitrequest = s_q.waitrequest;
   assign warning_irq = s_q.irq;
   assign exec_hold = s_q.hold;
   assign analog_ctrl.detector_enable = s_q.det_enable;
   assign analog_ctrl.sample_strobe = s_q.tick;
   assign analog_ctrl.threshold_level = s_q.threshold_level;
   assign analog_ctrl.warning_margin_select = s_q.warning_margin_select;
endmodule // bmr_registers

// ===== rtl/bmr_pkg.sv
// Shared constants and types for the brown-out monitor register bank
package bmr_pkg;

   // System clock and sampling rates
   localparam int unsigned BMR_CLK_HZ = 50_000_000;
   localparam int unsigned BMR_SAMPLE_FAST_HZ = 1000;
   localparam int unsigned BMR_SAMPLE_SLOW_HZ = 125;
   localparam int unsigned BMR_SAMPLE_FAST_CYCLES = BMR_CLK_HZ / BMR_SAMPLE_FAST_HZ;
   localparam int unsigned BMR_SAMPLE_SLOW_CYCLES = BMR_CLK_HZ / BMR_SAMPLE_SLOW_HZ;

   // Cycles that the protected field stays open after an unlock
   localparam int unsigned BMR_UNLOCK_WINDOW_CYCLES = 4;

   // Register indices; byte address is four times the index
   localparam logic [3:0] BMR_IDX_DETECTOR_CONTROL = 4'h0;
   localparam logic [3:0] BMR_IDX_THRESHOLD_LEVEL = 4'h1;
   localparam logic [3:0] BMR_IDX_WARNING_MARGIN_CONTROL = 4'h8;
   localparam logic [3:0] BMR_IDX_INTERRUPT_CONTROL = 4'h9;
   localparam logic [3:0] BMR_IDX_INTERRUPT_FLAGS = 4'hA;
   localparam logic [3:0] BMR_IDX_WARNING_STATUS = 4'hB;

   // Field positions
   localparam int unsigned BMR_LOWPOWER_LSB = 0;
   localparam int unsigned BMR_AWAKE_LSB = 2;
   localparam int unsigned BMR_RATE_BIT = 4;
   localparam int unsigned BMR_LEVEL_LSB = 0;
   localparam int unsigned BMR_MARGIN_LSB = 0;
   localparam int unsigned BMR_IRQ_EN_BIT = 0;
   localparam int unsigned BMR_DIR_LSB = 1;
   localparam int unsigned BMR_FLAG_BIT = 0;
   localparam int unsigned BMR_STATUS_BIT = 0;

   // Reset values of software fields
   localparam logic [1:0] BMR_MARGIN_RESET = 2'h0;
   localparam logic [1:0] BMR_DIR_RESET = 2'h0;
   localparam logic BMR_IRQ_EN_RESET = 1'b0;
   localparam logic BMR_FLAG_RESET = 1'b0;

   // Detector operating modes
   typedef enum logic [1:0] {
      BMR_MODE_OFF = 2'h0,
      BMR_MODE_CONTINUOUS = 2'h1,
      BMR_MODE_SAMPLED = 2'h2,
      BMR_MODE_WAKE_HOLD = 2'h3
   } bmr_mode_t;

   // Warning interrupt trigger direction
   typedef enum logic [1:0] {
      BMR_DIR_BELOW = 2'h0,
      BMR_DIR_ABOVE = 2'h1,
      BMR_DIR_CROSS = 2'h2,
      BMR_DIR_RESERVED = 2'h3
   } bmr_dir_t;

   // Bus handshake states
   typedef enum logic [1:0] {
      BMR_BUS_IDLE = 2'b01,
      BMR_BUS_ACK = 2'b10
   } bmr_bus_st_t;

   // Fuse values presented by the configuration loader
   typedef struct packed {
      logic sample_rate_select;
      bmr_mode_t awake_mode;
      bmr_mode_t lowpower_mode;
      logic [2:0] threshold_level;
   } bmr_fuse_t;

   // Controls toward the analog comparators
   typedef struct packed {
      logic detector_enable;
      logic sample_strobe;
      logic [2:0] threshold_level;
      logic [1:0] warning_margin_select;
   } bmr_analog_t;

endpackage

// ===== rtl/bmr_change_protect.sv
// Unlock window for the protected low-power-mode field
`timescale 1ns/1ps
module bmr_change_protect
   import bmr_pkg::*;
#(
   parameter int unsigned WINDOW_CYCLES = BMR_UNLOCK_WINDOW_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic unlock,
   input wire logic consume,
   output logic open_q
);
   localparam int unsigned CW = $clog2(WINDOW_CYCLES + 1);
   localparam logic [CW-1:0] WIN = CW'(WINDOW_CYCLES);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic open;
   } bmr_prot_state_t;

   bmr_prot_state_t s_q;
   bmr_prot_state_t s_d;

   always_comb begin
      s_d = s_q;
      // A fresh unlock restarts the window; a protected write uses it up
      if (unlock) begin
         s_d.cnt = WIN;
      end else if (consume) begin
         s_d.cnt = '0;
      end else if (s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - CW'(1);
      end
      s_d.open = (s_d.cnt != '0);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign open_q = s_q.open;
endmodule // bmr_change_protect

// ===== rtl/bmr_warning_detect.sv
// Synchroniser and crossing detector for the warning comparator
`timescale 1ns/1ps
module bmr_warning_detect
   import bmr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic below_raw,
   input wire logic active,
   input wire logic sampled,
   input wire logic tick,
   output logic below_q,
   output logic fell_q,
   output logic rose_q
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic level;
      logic valid;
      logic fell;
      logic rose;
      logic [1:0] settle;
   } bmr_warn_state_t;

   bmr_warn_state_t s_q;
   bmr_warn_state_t s_d;
   logic take;

   always_comb begin
      s_d = s_q;
      // The synchroniser still carries levels from before activation; wait until it has flushed
      if (!active) begin
         s_d.settle = 2'd0;
      end else if (s_q.settle != 2'd2) begin
         s_d.settle = s_q.settle + 2'd1;
      end
      take = active && (s_q.settle == 2'd2) && (!sampled || tick);
      s_d.sync1 = below_raw;
      s_d.sync2 = s_q.sync1;
      s_d.fell = 1'b0;
      s_d.rose = 1'b0;
      if (take) begin
         // First look after activation only primes the level, so no false crossing
         s_d.level = s_q.sync2;
         s_d.valid = 1'b1;
         s_d.fell = s_q.valid && s_q.sync2 && !s_q.level;
         s_d.rose = s_q.valid && !s_q.sync2 && s_q.level;
      end else if (!active) begin
         s_d.valid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign below_q = s_q.level;
   assign fell_q = s_q.fell;
   assign rose_q = s_q.rose;
endmodule // bmr_warning_detect

// ===== tb/bmr_registers_props.sv
// Port-level assertions for the brown-out monitor register bank
`timescale 1ns/1ps
module bmr_registers_props
   import bmr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire bmr_analog_t analog_ctrl,
   input wire logic warning_irq,
   input wire logic exec_hold
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   sequence s_rd(logic [3:0] i);
      avs_read && avs_waitrequest && avs_address[5:2] == i;
   endsequence
   property p_handshake;
      s_req |=> s_ans;
   endproperty
   a_handshake: assert property (p_handshake) else $error("request not answered after one cycle");
   property p_upper_zero;
      !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read data not zero");
   property p_unmapped;
      s_req ##0 avs_read && avs_address[5:2] inside {[2:7], [12:15]} |=> avs_readdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_level;
      s_rd(BMR_IDX_THRESHOLD_LEVEL) |=> avs_readdata == {29'h0, analog_ctrl.threshold_level};
   endproperty
   a_level: assert property (p_level) else $error("level read differs from output");
   property p_margin;
      s_rd(BMR_IDX_WARNING_MARGIN_CONTROL) |=> avs_readdata == {30'h0, analog_ctrl.warning_margin_select};
   endproperty
   a_margin: assert property (p_margin) else $error("margin read differs from output");
   property p_irq_off;
      avs_write && !avs_waitrequest && avs_byteenable[0] && !avs_writedata[0]
         && avs_address[5:2] == BMR_IDX_INTERRUPT_CONTROL |=> !warning_irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq high after disable");
   property p_irq_flag;
      warning_irq ##0 s_rd(BMR_IDX_INTERRUPT_FLAGS) |=> avs_readdata[0];
   endproperty
   a_irq_flag: assert property (p_irq_flag) else $error("irq high with flag clear");
   property p_after_reset;
      $rose(reset_n) |-> avs_waitrequest && !warning_irq && !exec_hold;
   endproperty
   a_after_reset: assert property (p_after_reset) else $error("outputs not idle after reset");
endmodule // bmr_registers_props

// ===== tb/bmr_partner.sv
// Model of the supply comparators and fuse loader
`timescale 1ns/1ps
module bmr_partner
   import bmr_pkg::*;
#(
   parameter bmr_fuse_t FUSE = 8'hA5,
   parameter int unsigned READY_DELAY = 3
) (
   input wire logic clk,
   input wire logic supply_below,
   input wire bmr_analog_t analog_ctrl,
   output bmr_fuse_t fuse_config,
   output logic warning_below_raw,
   output logic detector_ready_raw
);
   int unsigned run_cnt = 0;
   logic junk = 1'b0;
   assign fuse_config = FUSE;
   always @(posedge clk) begin
      junk <= !junk;
      run_cnt <= analog_ctrl.detector_enable ? run_cnt + 1 : 0;
   end
   // A disabled comparator has no valid level, so it shows a changing pattern
   assign warning_below_raw = analog_ctrl.detector_enable ? supply_below : junk;
   assign detector_ready_raw = run_cnt >= READY_DELAY;
endmodule // bmr_partner

// ===== tb/bmr_registers_tb.sv
// Self-checking bench for the brown-out monitor register bank
`timescale 1ns/1ps
module bmr_registers_tb;
   import bmr_pkg::*;
   localparam int unsigned SLOW = 20;
   localparam logic [5:0] A_CTL = 6'h00, A_LVL = 6'h04, A_MRG = 6'h20;
   localparam logic [5:0] A_INT = 6'h24, A_FLG = 6'h28, A_STA = 6'h2C;
   logic clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic sleep_deep = 1'b0, unlock = 1'b0, below = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [3:0] be = 4'hF;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, warning_irq, exec_hold, warning_below_raw, detector_ready_raw;
   bmr_fuse_t fuse_config;
   bmr_analog_t analog_ctrl;
   int n_mismatch = 0;
   int cmp_count = 0;

   bmr_registers #(.SAMPLE_FAST_CYCLES(8), .SAMPLE_SLOW_CYCLES(SLOW)) i_bmr_registers (
      .clk, .reset_n, .avs_address(addr), .avs_read, .avs_write, .avs_byteenable(be),
      .avs_writedata(wdata), .avs_readdata, .avs_waitrequest, .fuse_config, .sleep_deep,
      .config_change_unlock(unlock), .warning_below_raw, .detector_ready_raw,
      .analog_ctrl, .warning_irq, .exec_hold);
   bmr_partner i_bmr_partner (.clk, .supply_below(below), .analog_ctrl, .fuse_config,
      .warning_below_raw, .detector_ready_raw);

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Request is held until waitrequest is seen low, then released
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_read <= !wr;
      avs_write <= wr;
      addr <= a;
      wdata <= {24'h00_0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20) begin
         n_mismatch++;
         test_done;
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      check($sformatf("reg %h", a), q, {24'h00_0000, e});
   endtask
   task automatic unlock_wr(input logic [7:0] d);
      @(posedge clk);
      unlock <= 1'b1;
      @(posedge clk);
      unlock <= 1'b0;
      wr(A_CTL, d);
   endtask
   // Status is polled because the comparator path crosses synchronisers
   task automatic wait_stat(input logic v);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         bus(1'b0, A_STA, 8'h00, q);
         n++;
      end while (q[0] !== v && n < 20);
      check("status", q, {31'h0, v});
   endtask

   task automatic t_reset_vals;
      rd(A_CTL, 8'h14);
      rd(A_LVL, 8'h05);
      rd(A_MRG, 8'h00);
      rd(A_INT, 8'h00);
      rd(A_FLG, 8'h00);
      rd(A_STA, 8'h00);
      rd(6'h08, 8'h00);
   endtask
   task automatic t_protect;
      wr(A_CTL, 8'hFF);
      rd(A_CTL, 8'h14);
      unlock_wr(8'h0A);
      rd(A_CTL, 8'h16);
      wr(A_CTL, 8'h01);
      rd(A_CTL, 8'h16);
   endtask
   task automatic t_margin;
      for (int m = 0; m < 4; m++) begin
         wr(A_MRG, 8'(m));
         rd(A_MRG, 8'(m));
         check("margin out", {30'h0, analog_ctrl.warning_margin_select}, 32'(m));
      end
      be <= 4'h0;
      wr(A_MRG, 8'h01);
      be <= 4'hF;
      rd(A_MRG, 8'h03);
   endtask
   task automatic t_flags;
      logic e1;
      logic e2;
      for (int d = 0; d < 4; d++) begin
         e1 = d == 0 || d == 2;
         e2 = d == 1 || d == 2;
         wr(A_INT, {5'h00, 2'(d), 1'b1});
         rd(A_INT, {5'h00, 2'(d), 1'b1});
         below <= 1'b1;
         wait_stat(1'b1);
         rd(A_FLG, {7'h00, e1});
         check("irq", {31'h0, warning_irq}, {31'h0, e1});
         wr(A_FLG, 8'h01);
         rd(A_FLG, 8'h00);
         below <= 1'b0;
         wait_stat(1'b0);
         wr(A_FLG, 8'h00);
         rd(A_FLG, {7'h00, e2});
         wr(A_INT, {5'h00, 2'(d), 1'b0});
         @(negedge clk);
         check("irq off", {31'h0, warning_irq}, 32'h0000_0000);
         wr(A_FLG, 8'h01);
      end
   endtask
   task automatic t_sleep;
      int n;
      sleep_deep <= 1'b1;
      n = 0;
      while (analog_ctrl.sample_strobe !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (analog_ctrl.sample_strobe !== 1'b1 && n < 100);
      check("strobe gap", 32'(n), SLOW);
      check("enable", {31'h0, analog_ctrl.detector_enable}, 32'h0000_0001);
      wr(A_INT, 8'h05);
      unlock_wr(8'h00);
      below <= 1'b1;
      repeat (4) rd(A_FLG, 8'h00);
      check("enable off", {31'h0, analog_ctrl.detector_enable}, 32'h0000_0000);
      sleep_deep <= 1'b0;
      below <= 1'b0;
      wait_stat(1'b0);
      check("enable wake", {31'h0, analog_ctrl.detector_enable}, 32'h0000_0001);
      check("exec hold", {31'h0, exec_hold}, 32'h0000_0000);
      wr(A_FLG, 8'h01);
   endtask

   initial begin
      forever #10 clk = !clk;
   end
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      t_reset_vals;
      t_protect;
      t_margin;
      t_flags;
      t_sleep;
      test_done;
   end
endmodule // bmr_registers_tb

bind bmr_registers bmr_registers_props i_bmr_registers_props (.clk, .reset_n, .avs_address, .avs_read,
   .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .analog_ctrl,
   .warning_irq, .exec_hold);
